// >>> core/baro_status_output_regs.sv
// baro_status_output_regs: read-side status and result registers of the barometer.
// assumes the serial interface decoder gives a one-cycle read strobe with an address,
// and that the fifo, interrupt engine and conversion engine run on the same clk.
// configuration inputs are expected to change only between conversions.
// Functional notes
// - interrupt source bit 7 follows the running boot phase.
// - interrupt source bit 2 shows that some interrupt event occurred.
// - interrupt source bit 1 latches a low differential pressure event.
// - interrupt source bit 0 latches a high differential pressure event.
// - watermark flag is one when fill level is at or above threshold.
// - fifo status bit 6 shows full fifo with overwritten samples.
// - six-bit level field gives unread fifo samples, 32 when full.
// - data status bit 5 flags temperature result overwritten unread.
// - data status bit 4 flags pressure result overwritten unread.
// - data status bit 1 flags a new temperature result.
// - data status bit 0 flags a new pressure result.
// - visible data status refreshes once per output data rate period.
// - pressure is 24-bit two's complement, low byte 28h to high 2Ah.
// - with special modes off, pressure equals measured minus stored offset.
// - stored 16-bit offset is multiplied by 256 before subtracting.
// - temperature is 16-bit two's complement, low 2Bh, high 2Ch.
// - reading 33h resets the pressure low-pass filter; host reads it first.
// - watermark threshold is the 5-bit field of fifo control.
`timescale 1ns/1ps
module baro_status_output_regs (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register read port from the serial interface decoder
   input wire logic reg_rd_stb,
   input wire baro_regs_pkg::addr_t reg_addr,
   output baro_regs_pkg::byte_t reg_rd_data,
   output logic reg_rd_valid,
   // configuration held in the control bank
   input wire logic [baro_regs_pkg::THR_W-1:0] watermark_threshold,
   input wire logic [baro_regs_pkg::OFFS_W-1:0] pressure_offset,
   input wire logic differential_enable,
   input wire logic auto_reference_reset,
   input wire logic autozero_enable,
   // interrupt engine
   input wire logic boot_running,
   input wire logic low_diff_event,
   input wire logic high_diff_event,
   // fifo
   input wire logic [baro_regs_pkg::LEVEL_W-1:0] queue_level,
   input wire logic queue_overwrite,
   // conversion engine
   input wire logic output_data_rate_tick,
   input wire logic press_new,
   input wire logic [baro_regs_pkg::PRESS_W-1:0] press_raw,
   input wire logic temp_new,
   input wire logic [baro_regs_pkg::TEMP_W-1:0] temp_raw,
   // filter control
   output logic pressure_lowpass_reset
);
   import baro_regs_pkg::*;

   // register file state
   logic [PRESS_W-1:0] pressure_value;
   logic press_done;
   logic [TEMP_W-1:0] temperature_value_reg, temperature_value_next;
   logic boot_reg, boot_next;
   logic [LEVEL_W-1:0] level_reg, level_next;
   logic watermark_reg, watermark_next;
   byte_t status_view_reg, status_view_next;
   byte_t rd_data_reg, rd_data_next;
   logic rd_valid_reg, rd_valid_next;
   logic lp_reset_reg, lp_reset_next;

   // decoded read side effects
   logic rd_int_src, rd_fifo, rd_press_hi, rd_temp_hi, rd_lpf;
   logic subtract_en;
   // flag outputs of the sticky cells
   logic low_diff_flag, high_diff_flag, int_active_flag;
   logic queue_overrun_flag, queue_overrun_clr;
   logic press_ready_flag, temp_ready_flag;
   logic press_overrun_flag, temp_overrun_flag;
   logic press_overrun_set, temp_overrun_set;
   // byte images of the readable status registers
   byte_t int_src_byte, fifo_byte, status_live;

   // read strobes per register; only a read of the high byte ends the result read
   // the strobe is qualified once here so every side effect sees the same decode
   always_comb begin
      rd_int_src = reg_rd_stb && (reg_addr == INTERRUPT_SOURCE_FLAGS_ADDR);
      rd_fifo = reg_rd_stb && (reg_addr == FIFO_STATE_ADDR);
      rd_press_hi = reg_rd_stb && (reg_addr == PRESSURE_RESULT_HIGH_ADDR);
      rd_temp_hi = reg_rd_stb && (reg_addr == TEMPERATURE_RESULT_HIGH_ADDR);
      rd_lpf = reg_rd_stb && (reg_addr == FILTER_RESET_TRIGGER_ADDR);
   end

   // set and clear terms of the flags; any special pressure mode bypasses the offset
   always_comb begin
      subtract_en = ~(differential_enable | auto_reference_reset | autozero_enable);
      // a new result landing on a still-unread one is an overrun
      press_overrun_set = press_done & press_ready_flag;
      temp_overrun_set = temp_new & temp_ready_flag;
      // the overrun flag must outlive a read while the fifo is still full
      queue_overrun_clr = rd_fifo & (queue_level != LEVEL_FULL);
   end

   // pressure result with offset correction
   // the offset is removed at capture time, so every byte read sees the corrected value
   pressure_adjust u_press (
      .clk(clk),
      .rst(rst),
      .load(press_new),
      .raw(press_raw),
      .pressure_offset(pressure_offset),
      .subtract_en(subtract_en),
      .value_reg(pressure_value),
      .done_reg(press_done)
   );

   // latched interrupt sources, cleared by reading the interrupt source register
   // all three share one clear, so a single read empties every latched bit; boot bit 7 is a mirror and stays
   sticky_flag u_low (
      .clk(clk),
      .rst(rst),
      .set(low_diff_event),
      .clr(rd_int_src),
      .flag_reg(low_diff_flag)
   );
   sticky_flag u_high (
      .clk(clk),
      .rst(rst),
      .set(high_diff_event),
      .clr(rd_int_src),
      .flag_reg(high_diff_flag)
   );
   sticky_flag u_active (
      .clk(clk),
      .rst(rst),
      .set(low_diff_event | high_diff_event),
      .clr(rd_int_src),
      .flag_reg(int_active_flag)
   );

   // fifo overrun stays while the fifo is still full after overwrites
   sticky_flag u_qovr (
      .clk(clk),
      .rst(rst),
      .set(queue_overwrite),
      .clr(queue_overrun_clr),
      .flag_reg(queue_overrun_flag)
   );

   // result-ready and overrun flags; reading the high byte consumes the result
   sticky_flag u_pda (
      .clk(clk),
      .rst(rst),
      .set(press_done),
      .clr(rd_press_hi),
      .flag_reg(press_ready_flag)
   );
   sticky_flag u_tda (
      .clk(clk),
      .rst(rst),
      .set(temp_new),
      .clr(rd_temp_hi),
      .flag_reg(temp_ready_flag)
   );
   sticky_flag u_por (
      .clk(clk),
      .rst(rst),
      .set(press_overrun_set),
      .clr(rd_press_hi),
      .flag_reg(press_overrun_flag)
   );
   sticky_flag u_tor (
      .clk(clk),
      .rst(rst),
      .set(temp_overrun_set),
      .clr(rd_temp_hi),
      .flag_reg(temp_overrun_flag)
   );

   // temperature capture; the value and its ready flag move in the same cycle
   always_comb begin
      temperature_value_next = temp_new ? temp_raw : temperature_value_reg;
   end

   // boot mirror, fifo level and watermark compare, one cycle behind their sources
   always_comb begin
      boot_next = boot_running;
      level_next = queue_level;
      // equal-or-above wins over the looser greater-than wording
      watermark_next = (queue_level >= {1'b0, watermark_threshold});
   end

   // byte images of the three status registers, unused bits held at zero
   always_comb begin
      int_src_byte = BYTE_ZERO;
      int_src_byte[BOOT_BIT] = boot_reg;
      int_src_byte[ACTIVE_BIT] = int_active_flag;
      int_src_byte[LOW_BIT] = low_diff_flag;
      int_src_byte[HIGH_BIT] = high_diff_flag;
   end

   // fifo state image; level and watermark come from the registered mirrors
   always_comb begin
      fifo_byte = BYTE_ZERO;
      fifo_byte[WATERMARK_BIT] = watermark_reg;
      fifo_byte[QOVR_BIT] = queue_overrun_flag;
      fifo_byte[LEVEL_W-1:0] = level_reg;
   end

   // live data status image, ahead of the copy the host sees
   always_comb begin
      status_live = BYTE_ZERO;
      status_live[TOR_BIT] = temp_overrun_flag;
      status_live[POR_BIT] = press_overrun_flag;
      status_live[TDA_BIT] = temp_ready_flag;
      status_live[PDA_BIT] = press_ready_flag;
   end

   // visible status copies the live flags each rate tick; clears show at once,
   // so a host never sees a ready bit for data it already consumed
   always_comb begin
      status_view_next = status_view_reg;
      if (output_data_rate_tick) begin
         status_view_next = status_live;
      end
      // a tick in the reading cycle still copies the old live bits, so the clear
      // goes on top; a result landing in that cycle keeps its bits instead
      if (rd_press_hi && !press_done) begin
         status_view_next[PDA_BIT] = 1'b0;
         status_view_next[POR_BIT] = 1'b0;
      end
      if (rd_temp_hi && !temp_new) begin
         status_view_next[TDA_BIT] = 1'b0;
         status_view_next[TOR_BIT] = 1'b0;
      end
   end

   // read mux; unmapped addresses and the filter trigger read back zero
   always_comb begin
      // data holds its last value while no read is taken
      rd_data_next = rd_data_reg;
      rd_valid_next = reg_rd_stb;
      lp_reset_next = rd_lpf;
      if (reg_rd_stb) begin
         unique case (reg_addr)
            INTERRUPT_SOURCE_FLAGS_ADDR: rd_data_next = int_src_byte;
            FIFO_STATE_ADDR: rd_data_next = fifo_byte;
            DATA_STATUS_ADDR: rd_data_next = status_view_reg;
            PRESSURE_RESULT_LOW_ADDR: rd_data_next = pressure_value[7:0];
            PRESSURE_RESULT_MID_ADDR: rd_data_next = pressure_value[15:8];
            PRESSURE_RESULT_HIGH_ADDR: rd_data_next = pressure_value[23:16];
            TEMPERATURE_RESULT_LOW_ADDR: rd_data_next = temperature_value_reg[7:0];
            TEMPERATURE_RESULT_HIGH_ADDR: rd_data_next = temperature_value_reg[15:8];
            default: rd_data_next = BYTE_ZERO;
         endcase
      end
   end

   // result and mirror registers; the mirrors add one cycle to the boot, level and watermark sources
   always_ff @(posedge clk) begin
      if (rst) begin
         temperature_value_reg <= TEMP_RESET;
         boot_reg <= 1'b0;
         level_reg <= '0;
         watermark_reg <= 1'b0;
      end else begin
         temperature_value_reg <= temperature_value_next;
         boot_reg <= boot_next;
         level_reg <= level_next;
         watermark_reg <= watermark_next;
      end
   end

   // host-visible data status, changed only by rate ticks and result reads
   always_ff @(posedge clk) begin
      if (rst) begin
         status_view_reg <= BYTE_ZERO;
      end else begin
         status_view_reg <= status_view_next;
      end
   end

   // read port answer; data holds between reads so a slow decoder can sample late
   always_ff @(posedge clk) begin
      if (rst) begin
         rd_data_reg <= BYTE_ZERO;
         rd_valid_reg <= 1'b0;
      end else begin
         rd_data_reg <= rd_data_next;
         rd_valid_reg <= rd_valid_next;
      end
   end

   // filter reset pulse, one cycle after the trigger read is taken
   always_ff @(posedge clk) begin
      if (rst) begin
         lp_reset_reg <= 1'b0;
      end else begin
         lp_reset_reg <= lp_reset_next;
      end
   end

   assign reg_rd_data = rd_data_reg;
   assign reg_rd_valid = rd_valid_reg;
   assign pressure_lowpass_reset = lp_reset_reg;
endmodule // baro_status_output_regs

// >>> core/baro_regs_pkg.sv
// baro_regs_pkg: offsets, bit positions and widths of the read-side status and result bank.
// assumes byte-wide registers on an 8-bit internal address, one clock domain.
package baro_regs_pkg;
   // widths
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int PRESS_W = 24;
   localparam int TEMP_W = 16;
   localparam int OFFS_W = 16;
   localparam int LEVEL_W = 6;
   localparam int THR_W = 5;
   localparam int OFFS_SHIFT = 8; // offset scaled by 256
   typedef logic [ADDR_W-1:0] addr_t;
   typedef logic [DATA_W-1:0] byte_t;

   // register offsets
   localparam addr_t INTERRUPT_SOURCE_FLAGS_ADDR = 8'h25;
   localparam addr_t FIFO_STATE_ADDR = 8'h26;
   localparam addr_t DATA_STATUS_ADDR = 8'h27;
   localparam addr_t PRESSURE_RESULT_LOW_ADDR = 8'h28;
   localparam addr_t PRESSURE_RESULT_MID_ADDR = 8'h29;
   localparam addr_t PRESSURE_RESULT_HIGH_ADDR = 8'h2A;
   localparam addr_t TEMPERATURE_RESULT_LOW_ADDR = 8'h2B;
   localparam addr_t TEMPERATURE_RESULT_HIGH_ADDR = 8'h2C;
   localparam addr_t FILTER_RESET_TRIGGER_ADDR = 8'h33;

   // interrupt_source_flags fields
   localparam int BOOT_BIT = 7;
   localparam int ACTIVE_BIT = 2;
   localparam int LOW_BIT = 1;
   localparam int HIGH_BIT = 0;
   // fifo_state fields
   localparam int WATERMARK_BIT = 7;
   localparam int QOVR_BIT = 6;
   localparam logic [LEVEL_W-1:0] LEVEL_FULL = 6'h20; // 32 unread samples
   // data_status fields
   localparam int TOR_BIT = 5;
   localparam int POR_BIT = 4;
   localparam int TDA_BIT = 1;
   localparam int PDA_BIT = 0;

   // reset and idle values
   localparam byte_t BYTE_ZERO = 8'h00;
   localparam logic [PRESS_W-1:0] PRESS_RESET = 24'h000000;
   localparam logic [TEMP_W-1:0] TEMP_RESET = 16'h0000;
endpackage

// >>> core/sticky_flag.sv
// sticky_flag: one hardware-set, reader-cleared flag.
// assumes set and clear are single-cycle pulses on clk.
`timescale 1ns/1ps
module sticky_flag (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // set and clear
   input wire logic set,
   input wire logic clr,
   // flag
   output logic flag_reg
);
   logic flag_next;

   // a set in the clearing cycle wins so no event is lost
   always_comb begin
      flag_next = set | (flag_reg & ~clr);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         flag_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
      end
   end
endmodule // sticky_flag

// >>> core/pressure_adjust.sv
// pressure_adjust: registers a new pressure result, minus the scaled stored offset.
// assumes raw and offset are stable in the cycle that load is high.
`timescale 1ns/1ps
module pressure_adjust (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // conversion input
   input wire logic load,
   input wire logic [baro_regs_pkg::PRESS_W-1:0] raw,
   input wire logic [baro_regs_pkg::OFFS_W-1:0] pressure_offset,
   input wire logic subtract_en,
   // result
   output logic [baro_regs_pkg::PRESS_W-1:0] value_reg,
   output logic done_reg
);
   import baro_regs_pkg::*;
   logic [PRESS_W-1:0] value_next;
   logic [PRESS_W-1:0] scaled_offset;

   // offset is 16 bits, shifted up to line up with the 24-bit result
   always_comb begin
      scaled_offset = {pressure_offset, {OFFS_SHIFT{1'b0}}};
      value_next = value_reg;
      if (load) begin
         // two's complement wraps; no saturation, matching the raw width
         value_next = subtract_en ? PRESS_W'(raw - scaled_offset) : raw;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         value_reg <= PRESS_RESET;
         done_reg <= 1'b0;
      end else begin
         value_reg <= value_next;
         done_reg <= load;
      end
   end
endmodule // pressure_adjust

// >>> tb/baro_status_chk.sv
// baro_status_chk: port-level properties of the status and result bank.
// assumes one clock and the block's synchronous active-high reset.
`timescale 1ns/1ps
module baro_status_chk (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // read port
   input wire logic reg_rd_stb,
   input wire baro_regs_pkg::addr_t reg_addr,
   input wire baro_regs_pkg::byte_t reg_rd_data,
   // sources
   input wire logic [baro_regs_pkg::THR_W-1:0] watermark_threshold,
   input wire logic boot_running,
   input wire logic [baro_regs_pkg::LEVEL_W-1:0] queue_level,
   input wire logic queue_overwrite,
   // filter control
   input wire logic pressure_lowpass_reset
);
   import baro_regs_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // decoded reads; sources held for a cycle hide the one-cycle mirror delay
   logic rd_int, rd_fifo, rd_stat, rd_lpf;
   assign rd_int = reg_rd_stb && reg_addr == INTERRUPT_SOURCE_FLAGS_ADDR;
   assign rd_fifo = reg_rd_stb && reg_addr == FIFO_STATE_ADDR;
   assign rd_stat = reg_rd_stb && reg_addr == DATA_STATUS_ADDR;
   assign rd_lpf = reg_rd_stb && reg_addr == FILTER_RESET_TRIGGER_ADDR;
   property p_boot;
      rd_int && $stable(boot_running) && !$past(rst)
         |=> reg_rd_data[BOOT_BIT] == $past(boot_running);
   endproperty
   a_boot: assert property (p_boot) else $error("boot flag not mirrored");
   property p_ia;
      rd_int |=> reg_rd_data[ACTIVE_BIT] == (reg_rd_data[LOW_BIT] | reg_rd_data[HIGH_BIT]);
   endproperty
   a_ia: assert property (p_ia) else $error("active flag disagrees with events");
   property p_int_zero;
      rd_int |=> reg_rd_data[6:3] == 4'h0;
   endproperty
   a_int_zero: assert property (p_int_zero) else $error("unused source bits set");
   property p_level;
      rd_fifo && $stable(queue_level) && !$past(rst) |=> reg_rd_data[5:0] == $past(queue_level);
   endproperty
   a_level: assert property (p_level) else $error("fill level wrong");
   property p_wtm;
      rd_fifo && $stable(queue_level) && $stable(watermark_threshold) && !$past(rst)
         |=> reg_rd_data[WATERMARK_BIT] == ($past(queue_level) >= $past(watermark_threshold));
   endproperty
   a_wtm: assert property (p_wtm) else $error("watermark flag wrong");
   property p_stat_zero;
      rd_stat |=> reg_rd_data[7:6] == 2'h0 && reg_rd_data[3:2] == 2'h0;
   endproperty
   a_stat_zero: assert property (p_stat_zero) else $error("unused status bits");
   // the pulse ends after one cycle unless a second trigger read follows at once
   property p_lpf;
      rd_lpf |=> pressure_lowpass_reset ##1 (pressure_lowpass_reset == $past(rd_lpf));
   endproperty
   a_lpf: assert property (p_lpf) else $error("filter reset pulse missing");
   property p_lpf_only;
      pressure_lowpass_reset |-> $past(rd_lpf);
   endproperty
   a_lpf_only: assert property (p_lpf_only) else $error("stray filter reset");
   // main scenarios reached
   c_overwrite: cover property (queue_overwrite && queue_level == LEVEL_FULL);
   c_press_hi: cover property (reg_rd_stb && reg_addr == PRESSURE_RESULT_HIGH_ADDR);
   c_lpf: cover property (rd_lpf);
endmodule // baro_status_chk

// >>> tb/host_reader.sv
// host_reader: host side of the decoded read port, one read at a time.
// assumes the answer comes one cycle after the strobe is taken.
`timescale 1ns/1ps
module host_reader (
   // clock
   input wire logic clk,
   // read port
   output logic reg_rd_stb,
   output baro_regs_pkg::addr_t reg_addr,
   input wire baro_regs_pkg::byte_t reg_rd_data,
   input wire logic reg_rd_valid
);
   import baro_regs_pkg::*;
   initial begin
      reg_rd_stb = 1'b0;
      reg_addr = 8'h00;
   end
   // one-cycle strobe; the address is scrambled after use so stale values never match
   task automatic rd(input addr_t a, output byte_t d, output logic ok);
      @(posedge clk);
      reg_rd_stb <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd_stb <= 1'b0;
      reg_addr <= ~a;
      @(posedge clk);
      ok = reg_rd_valid;
      d = reg_rd_data;
   endtask
endmodule // host_reader

// >>> tb/baro_status_output_regs_tb.sv
// baro_status_output_regs_tb: directed scenarios for the status and result bank.
// assumes host_reader as the only reader and the bound checker.
`timescale 1ns/1ps
module baro_status_output_regs_tb;
   import baro_regs_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic reg_rd_stb, reg_rd_valid, pressure_lowpass_reset;
   addr_t reg_addr;
   byte_t reg_rd_data;
   logic [4:0] thr = 5'h01;
   logic [15:0] offs = 16'h0000;
   logic [2:0] modes = 3'b000;
   logic boot = 1'b0;
   logic [5:0] lvl = 6'h00;
   logic [5:0] ev = 6'h00; // low, high, overwrite, tick, press, temp
   logic [23:0] praw = 24'h000000;
   logic [15:0] traw = 16'h0000;
   int fail_count = 0;
   int num_checks = 0;
   always #4 clk = ~clk;
   baro_status_output_regs u_baro_status_output_regs (
      .clk, .rst, .reg_rd_stb, .reg_addr, .reg_rd_data, .reg_rd_valid,
      .watermark_threshold(thr), .pressure_offset(offs), .differential_enable(modes[0]),
      .auto_reference_reset(modes[1]), .autozero_enable(modes[2]), .boot_running(boot),
      .low_diff_event(ev[0]), .high_diff_event(ev[1]), .queue_level(lvl),
      .queue_overwrite(ev[2]), .output_data_rate_tick(ev[3]), .press_new(ev[4]),
      .press_raw(praw), .temp_new(ev[5]), .temp_raw(traw), .pressure_lowpass_reset);
   host_reader u_host_reader (.clk, .reg_rd_stb, .reg_addr, .reg_rd_data, .reg_rd_valid);
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // read and compare; a missing valid turns the seen value unknown so it cannot match
   task automatic rdchk(input addr_t a, input byte_t exp);
      byte_t d;
      logic ok;
      u_host_reader.rd(a, d, ok);
      if (ok !== 1'b1) d = 8'hXX;
      check(a, d, exp);
   endtask
   // compare one byte; unknown bits never match
   task automatic check(input addr_t a, input byte_t seen, input byte_t exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] reg %h expected %h seen %h", a, exp, seen);
      end
   endtask
   // one-cycle event pulses with their conversion values
   task automatic drive(input logic [5:0] m, input logic [23:0] p, input logic [15:0] t);
      @(posedge clk);
      praw <= p;
      traw <= t;
      ev <= m;
      @(posedge clk);
      ev <= 6'h00;
   endtask
   task automatic fifo(input logic [5:0] l, input logic [4:0] t, input byte_t exp);
      @(posedge clk);
      lvl <= l;
      thr <= t;
      rdchk(FIFO_STATE_ADDR, exp);
   endtask
   task automatic prd(input logic [23:0] v);
      rdchk(PRESSURE_RESULT_LOW_ADDR, v[7:0]);
      rdchk(PRESSURE_RESULT_MID_ADDR, v[15:8]);
      rdchk(PRESSURE_RESULT_HIGH_ADDR, v[23:16]);
   endtask
   // filter reset read comes first, before any measurement
   task automatic t_idle;
      rdchk(FILTER_RESET_TRIGGER_ADDR, 8'h00);
      rdchk(INTERRUPT_SOURCE_FLAGS_ADDR, 8'h00);
      rdchk(DATA_STATUS_ADDR, 8'h00);
      rdchk(8'h30, 8'h00);
   endtask
   task automatic t_int;
      @(posedge clk);
      boot <= 1'b1;
      drive(6'h01, praw, traw);
      rdchk(INTERRUPT_SOURCE_FLAGS_ADDR, 8'h86);
      @(posedge clk);
      boot <= 1'b0;
      drive(6'h02, praw, traw);
      rdchk(INTERRUPT_SOURCE_FLAGS_ADDR, 8'h05);
      rdchk(INTERRUPT_SOURCE_FLAGS_ADDR, 8'h00);
      // a low event in the very cycle the clearing read is taken must survive it
      fork
         rdchk(INTERRUPT_SOURCE_FLAGS_ADDR, 8'h00);
         drive(6'h01, praw, traw);
      join
      rdchk(INTERRUPT_SOURCE_FLAGS_ADDR, 8'h06);
      rdchk(INTERRUPT_SOURCE_FLAGS_ADDR, 8'h00);
   endtask
   task automatic t_fifo;
      fifo(6'h00, 5'h01, 8'h00);
      fifo(6'h20, 5'h1F, 8'hA0);
      fifo(6'h05, 5'h05, 8'h85);
      fifo(6'h05, 5'h06, 8'h05);
      fifo(6'h20, 5'h06, 8'hA0);
      drive(6'h04, praw, traw);
      fifo(6'h20, 5'h06, 8'hE0);
      fifo(6'h1F, 5'h06, 8'hDF);
      fifo(6'h1F, 5'h06, 8'h9F);
   endtask
   task automatic t_press;
      @(posedge clk);
      offs <= 16'h0012;
      drive(6'h10, 24'h123456, traw);
      repeat (2) @(posedge clk);
      rdchk(DATA_STATUS_ADDR, 8'h00);
      drive(6'h08, praw, traw);
      rdchk(DATA_STATUS_ADDR, 8'h01);
      prd(24'h122256);
      rdchk(DATA_STATUS_ADDR, 8'h00);
      @(posedge clk);
      offs <= 16'h0002;
      drive(6'h10, 24'h000100, traw);
      repeat (2) @(posedge clk);
      drive(6'h10, 24'h000180, traw);
      repeat (2) @(posedge clk);
      drive(6'h08, praw, traw);
      rdchk(DATA_STATUS_ADDR, 8'h11);
      prd(24'hFFFF80);
      rdchk(DATA_STATUS_ADDR, 8'h00);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         modes <= 3'h1 << i;
         drive(6'h10, 24'hABCDEF, traw);
         @(posedge clk);
         prd(24'hABCDEF);
      end
   endtask
   task automatic t_temp;
      drive(6'h20, praw, 16'h7FFE);
      repeat (2) @(posedge clk);
      drive(6'h20, praw, 16'h8001);
      repeat (2) @(posedge clk);
      drive(6'h08, praw, traw);
      rdchk(DATA_STATUS_ADDR, 8'h22);
      rdchk(TEMPERATURE_RESULT_LOW_ADDR, 8'h01);
      rdchk(TEMPERATURE_RESULT_HIGH_ADDR, 8'h80);
      rdchk(DATA_STATUS_ADDR, 8'h00);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_idle();
      t_int();
      t_fifo();
      t_press();
      t_temp();
      end_sim();
   end
   // the sequence needs well under a thousand cycles
   initial begin
      repeat (3000) @(posedge clk);
      fail_count++;
      end_sim();
   end
endmodule // baro_status_output_regs_tb
bind baro_status_output_regs baro_status_chk u_baro_status_chk (
   .clk, .rst, .reg_rd_stb, .reg_addr, .reg_rd_data, .watermark_threshold,
   .boot_running, .queue_level, .queue_overwrite, .pressure_lowpass_reset);
